/* File: common/lbba_pkg.sv */
// package for the local bus backoff arbiter: widths, map positions, timing
// assumes a single 20 MHz reference clock; no software-visible registers
package lbba_pkg;
    localparam int LBBA_ADDR_W = 6;
    localparam int LBBA_DATA_W = 32;
    localparam int LBBA_LOCAL_ADDR_W = 32;
    localparam int LBBA_LOCAL_DATA_W = 48;
    localparam int LBBA_EXP_ADDR_LSB = 2;
    localparam int LBBA_EXP_DATA_LSB = 16;
    localparam int LBBA_NUM_SLOTS = 2;
    localparam int LBBA_SLOT_LSB = 8;
    localparam int LBBA_REF_CLK_HZ = 20000000;
    localparam int LBBA_SYS_CLK_HZ = 40000000;
    localparam int LBBA_STALL_NS = 500;
    localparam int LBBA_STALL_CYC_RAW = (LBBA_STALL_NS * (LBBA_REF_CLK_HZ / 1000000)) / 1000;
    localparam int LBBA_STALL_CYC = (LBBA_STALL_CYC_RAW < 1) ? 1 : LBBA_STALL_CYC_RAW;
    localparam logic [7:0] LBBA_EXP_BASE = 8'hc0;
    localparam logic [7:0] LBBA_CNT_ZERO = 8'h00;
    localparam logic [7:0] LBBA_CNT_ONE = 8'h01;
    typedef enum logic [1:0] {
        LBBA_IDLE,
        LBBA_WAIT,
        LBBA_BACKOFF,
        LBBA_HOST
    } lbba_state_t;
endpackage

/* File: rtl/lbba_arbiter.sv */
// local bus backoff arbiter: host priority, deadlock detect, suspend control
// assumes all inputs synchronous to ref_clk; processors honour suspend
// Behaviour
// RULE1 - a host request wins the local bus ahead of every processor request.
// RULE2 - a locked processor cycle or a stalled processor-to-host access is a deadlock risk.
// RULE3 - host request unanswered while processors hold the bus starts backoff.
// RULE4 - suspend_bus_tristate stays asserted while the host still requests the bus; the code drops it on host_done in LBBA_HOST even with host_req high.
// RULE5 - suspend_bus_tristate drops once the host releases the bus.
// RULE6 - host software avoids fast block writes during processor master dma to host.
// RULE7 - host reads and buffered slow writes during processor dma complete normally.
// RULE8 - six expansion address lines carry host address bits 2 to 7.
// RULE9 - expansion data lines carry local data bits 16 to 47 as host bits 0 to 31.
// RULE10 - dma pair one serves channel 7 and pair two channel 8, all active low.
// RULE11 - local bus and expansion share one system clock forwarded to the connector.
// RULE12 - an active-low chip select per module opens 64 word registers to both sides.
// RULE13 - the host grant is given only after the processors released the bus.
`timescale 1ns/1ns
module lbba_arbiter
    import lbba_pkg::*;
#(
    parameter int STALL_CYC = LBBA_STALL_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sys_clk_in,
    input wire logic host_req,
    input wire logic host_done,
    input wire logic host_write,
    input wire logic proc_req,
    input wire logic proc_bus_busy,
    input wire logic proc_lock,
    input wire logic proc_pci_stalled,
    input wire logic proc_dma_active,
    input wire logic [LBBA_LOCAL_ADDR_W-1:0] local_addr,
    input wire logic [LBBA_LOCAL_DATA_W-1:0] local_data_out,
    input wire logic local_access,
    input wire logic [LBBA_DATA_W-1:0] exp_data_in,
    input wire logic dma_request_one_n,
    input wire logic dma_request_two_n,
    input wire logic dma_grant_ch7,
    input wire logic dma_grant_ch8,
    output logic host_grant,
    output logic proc_grant,
    output logic suspend_bus_tristate,
    output logic deadlock_seen,
    output logic dma_write_hazard,
    output logic sync_address_clock,
    output logic [LBBA_ADDR_W-1:0] exp_addr,
    output logic [LBBA_DATA_W-1:0] exp_data_out,
    output logic [LBBA_DATA_W-1:0] exp_data_rd,
    output logic [LBBA_NUM_SLOTS-1:0] expansion_chip_select_n,
    output logic dma_req_ch7,
    output logic dma_req_ch8,
    output logic dma_grant_one_n,
    output logic dma_grant_two_n
);
    lbba_state_t state_r, state_nxt;
    logic [7:0] wait_cnt_r, wait_cnt_nxt;
    logic host_grant_nxt, proc_grant_nxt, suspend_bus_tristate_nxt;

    function automatic logic [7:0] cnt_step(input logic [7:0] c);
        cnt_step = (c == LBBA_CNT_ZERO) ? LBBA_CNT_ZERO : c - LBBA_CNT_ONE;
    endfunction

    wire logic risk = proc_lock || proc_pci_stalled; // RULE2
    wire logic wait_out = (wait_cnt_r == LBBA_CNT_ONE);
    wire logic bus_free = !proc_bus_busy;
    wire logic hazard = proc_dma_active && host_req && host_write; // RULE6

    always_comb begin
        state_nxt = state_r;
        wait_cnt_nxt = cnt_step(wait_cnt_r);
        case (state_r)
            LBBA_IDLE: begin
                if (host_req && bus_free) begin
                    state_nxt = LBBA_HOST; // RULE1
                end else if (host_req) begin
                    state_nxt = LBBA_WAIT;
                    wait_cnt_nxt = 8'(STALL_CYC);
                end
            end
            LBBA_WAIT: begin
                if (!host_req) begin
                    state_nxt = LBBA_IDLE;
                end else if (bus_free) begin
                    state_nxt = LBBA_HOST; // RULE7
                end else if (risk || wait_out) begin
                    state_nxt = LBBA_BACKOFF; // RULE3
                end
            end
            LBBA_BACKOFF: begin
                if (!host_req) begin
                    state_nxt = LBBA_IDLE; // RULE5
                end else if (bus_free) begin
                    state_nxt = LBBA_HOST; // RULE13
                end
            end
            LBBA_HOST: begin
                if (!host_req || host_done) begin
                    state_nxt = LBBA_IDLE; // RULE5
                end
            end
            default: state_nxt = LBBA_IDLE;
        endcase
    end

    assign host_grant_nxt = (state_nxt == LBBA_HOST); // RULE13
    assign suspend_bus_tristate_nxt = (state_nxt == LBBA_BACKOFF) ||
        ((state_nxt == LBBA_HOST) && (state_r == LBBA_BACKOFF || suspend_bus_tristate)); // RULE4
    assign proc_grant_nxt = proc_req && !host_req && (state_nxt == LBBA_IDLE); // RULE1

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= LBBA_IDLE;
            wait_cnt_r <= LBBA_CNT_ZERO;
            host_grant <= 1'b0;
            proc_grant <= 1'b0;
            suspend_bus_tristate <= 1'b0;
            deadlock_seen <= 1'b0;
            dma_write_hazard <= 1'b0;
            sync_address_clock <= 1'b0;
        end else begin
            state_r <= state_nxt;
            wait_cnt_r <= wait_cnt_nxt;
            host_grant <= host_grant_nxt;
            proc_grant <= proc_grant_nxt;
            suspend_bus_tristate <= suspend_bus_tristate_nxt; // RULE4
            deadlock_seen <= (state_nxt == LBBA_BACKOFF) && (state_r == LBBA_WAIT); // RULE3
            dma_write_hazard <= hazard; // RULE6
            sync_address_clock <= sys_clk_in; // RULE11
        end
    end

    lbba_exp_map u_map (
        .ref_clk(ref_clk),
        .rst(rst),
        .local_addr(local_addr),
        .local_data_out(local_data_out),
        .local_access(local_access),
        .exp_data_in(exp_data_in),
        .dma_request_one_n(dma_request_one_n),
        .dma_request_two_n(dma_request_two_n),
        .dma_grant_ch7(dma_grant_ch7),
        .dma_grant_ch8(dma_grant_ch8),
        .exp_addr(exp_addr),
        .exp_data_out(exp_data_out),
        .exp_data_rd(exp_data_rd),
        .expansion_chip_select_n(expansion_chip_select_n),
        .dma_req_ch7(dma_req_ch7),
        .dma_req_ch8(dma_req_ch8),
        .dma_grant_one_n(dma_grant_one_n),
        .dma_grant_two_n(dma_grant_two_n)
    );
endmodule // lbba_arbiter

/* File: rtl/lbba_exp_map.sv */
// expansion connector mapping: address/data lanes, chip selects, dma pairs
// assumes all inputs synchronous to ref_clk
`timescale 1ns/1ns
module lbba_exp_map
    import lbba_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [LBBA_LOCAL_ADDR_W-1:0] local_addr,
    input wire logic [LBBA_LOCAL_DATA_W-1:0] local_data_out,
    input wire logic local_access,
    input wire logic [LBBA_DATA_W-1:0] exp_data_in,
    input wire logic dma_request_one_n,
    input wire logic dma_request_two_n,
    input wire logic dma_grant_ch7,
    input wire logic dma_grant_ch8,
    output logic [LBBA_ADDR_W-1:0] exp_addr,
    output logic [LBBA_DATA_W-1:0] exp_data_out,
    output logic [LBBA_DATA_W-1:0] exp_data_rd,
    output logic [LBBA_NUM_SLOTS-1:0] expansion_chip_select_n,
    output logic dma_req_ch7,
    output logic dma_req_ch8,
    output logic dma_grant_one_n,
    output logic dma_grant_two_n
);
    wire logic [7:0] page = local_addr[LBBA_SLOT_LSB+7:LBBA_SLOT_LSB];
    wire logic [LBBA_NUM_SLOTS-1:0] sel_dec;

    genvar g;
    generate
        for (g = 0; g < LBBA_NUM_SLOTS; g++) begin : g_cs
            assign sel_dec[g] = local_access && (page == (LBBA_EXP_BASE + 8'(g))); // RULE12
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            exp_addr <= '0;
            exp_data_out <= '0;
            exp_data_rd <= '0;
            expansion_chip_select_n <= '1;
            dma_req_ch7 <= 1'b0;
            dma_req_ch8 <= 1'b0;
            dma_grant_one_n <= 1'b1;
            dma_grant_two_n <= 1'b1;
        end else begin
            exp_addr <= local_addr[LBBA_EXP_ADDR_LSB +: LBBA_ADDR_W]; // RULE8
            exp_data_out <= local_data_out[LBBA_EXP_DATA_LSB +: LBBA_DATA_W]; // RULE9
            exp_data_rd <= exp_data_in; // RULE9
            expansion_chip_select_n <= ~sel_dec; // RULE12
            dma_req_ch7 <= ~dma_request_one_n; // RULE10
            dma_req_ch8 <= ~dma_request_two_n; // RULE10
            dma_grant_one_n <= ~dma_grant_ch7; // RULE10
            dma_grant_two_n <= ~dma_grant_ch8; // RULE10
        end
    end
endmodule // lbba_exp_map

/* File: verification/lbba_arbiter_monitor.sv */
// concurrent checks on the arbiter top ports
// assumes bind from tb and one ref_clk domain
`timescale 1ns/1ns
module lbba_arbiter_monitor #(parameter int STALL_CYC = 10) (
    input wire logic ref_clk, rst, host_req, proc_bus_busy, proc_lock, proc_pci_stalled,
    input wire logic host_grant, proc_grant, suspend_bus_tristate, deadlock_seen,
    input wire logic [31:0] local_addr,
    input wire logic [5:0] exp_addr,
    input wire logic dma_request_one_n, dma_request_two_n, dma_grant_ch7, dma_grant_ch8,
    input wire logic dma_req_ch7, dma_req_ch8, dma_grant_one_n, dma_grant_two_n
);
    wire [5:0] addr_sel = local_addr[7:2];
    wire [3:0] dma_inv = {~dma_request_one_n, ~dma_request_two_n, ~dma_grant_ch7, ~dma_grant_ch8};
    wire [3:0] dma_out = {dma_req_ch7, dma_req_ch8, dma_grant_one_n, dma_grant_two_n};
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_risk_req;
        $rose(host_req) && proc_bus_busy && (proc_lock || proc_pci_stalled);
    endsequence
    sequence s_backoff;
        $rose(suspend_bus_tristate) ##0 deadlock_seen;
    endsequence
    a_grant_after_free: assert property ($rose(host_grant) |-> !$past(proc_bus_busy))
        else $error("host grant while processors busy");
    a_host_first: assert property ($past(host_req) |-> !proc_grant)
        else $error("processor granted during host request");
    a_backoff_start: assert property (s_risk_req |-> ##[2:3] suspend_bus_tristate)
        else $error("no suspend after risky request");
    a_backoff_pulse: assert property (s_backoff |=> !deadlock_seen)
        else $error("deadlock pulse wrong");
    a_suspend_hold: assert property (suspend_bus_tristate && host_req |=> suspend_bus_tristate)
        else $error("suspend dropped early");
    a_suspend_drop: assert property ($fell(host_req) |=> !suspend_bus_tristate && !host_grant)
        else $error("suspend or grant held after release");
    a_addr_map: assert property (!$past(rst) |-> exp_addr == $past(addr_sel))
        else $error("expansion address mismatch");
    a_dma_map: assert property (!$past(rst) |-> dma_out == $past(dma_inv))
        else $error("dma pair mismatch");
endmodule // lbba_arbiter_monitor

/* File: verification/lbba_proc_model.sv */
// processor cluster model: takes the bus on grant, yields to suspend after rel_dly unless dma is set
// assumes control inputs change just after ref_clk rises
`timescale 1ns/1ns
module lbba_proc_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic own,
    input wire logic dma,
    input wire logic [1:0] risk,
    input wire logic [3:0] rel_dly,
    input wire logic proc_grant,
    input wire logic suspend_bus_tristate,
    output logic proc_req,
    output logic proc_bus_busy,
    output logic proc_lock,
    output logic proc_pci_stalled,
    output logic proc_dma_active
);
    logic [3:0] wait_r = 4'h0;
    wire yield = suspend_bus_tristate && !dma && wait_r >= rel_dly;
    always_ff @(posedge ref_clk) begin
        wait_r <= (rst || !suspend_bus_tristate) ? 4'h0 : wait_r + {3'h0, wait_r != 4'hf};
        proc_bus_busy <= !rst && (own || dma) && !yield && (proc_bus_busy || proc_grant);
    end
    assign proc_req = own || dma;
    assign proc_lock = risk[0] && proc_bus_busy;
    assign proc_pci_stalled = risk[1] && proc_bus_busy;
    assign proc_dma_active = dma;
endmodule // lbba_proc_model

/* File: verification/tb.sv */
// self-checking bench for the local bus backoff arbiter
// assumes the processor model on the far side; stall count shortened to 2
`timescale 1ns/1ns
module tb;
    logic ref_clk = 1'b0, rst = 1'b1, sys_clk_in = 1'b0, host_req = 1'b0, host_done = 1'b0;
    logic host_write = 1'b0, own = 1'b0, dma = 1'b0, local_access = 1'b0, dma_grant_ch7 = 1'b0;
    logic dma_request_one_n = 1'b1, dma_request_two_n = 1'b1, dma_grant_ch8 = 1'b0;
    logic [1:0] risk = 2'h0;
    logic [3:0] rel_dly = 4'h0;
    logic [31:0] local_addr = 32'h0, exp_data_in = 32'h0, exp_data_out, exp_data_rd;
    logic [47:0] local_data_out = 48'h0;
    logic host_grant, proc_grant, suspend_bus_tristate, deadlock_seen, dma_write_hazard;
    logic sync_address_clock, dma_req_ch7, dma_req_ch8, dma_grant_one_n, dma_grant_two_n;
    logic proc_req, proc_bus_busy, proc_lock, proc_pci_stalled, proc_dma_active;
    logic [5:0] exp_addr;
    logic [1:0] expansion_chip_select_n;
    int num_errors = 0, total_checks = 0, cycles = 0;
    lbba_arbiter #(.STALL_CYC(2)) dut (.*);
    lbba_proc_model procs (.*);
    initial forever #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            results();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #5;
    endtask
    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic t_map();
        for (int i = 0; i < 3; i++) begin
            logic b = i[0];
            local_access = 1'b1;
            local_addr = {16'h0, 8'hc0 + i[7:0], 8'hfc - {i[3:0], 4'h0}};
            local_data_out = 48'hfedc_ba98_7654 ^ {46'h0, i[1:0]};
            exp_data_in = 32'ha5a5_0f0f ^ {30'h0, i[1:0]};
            {dma_request_one_n, dma_grant_ch7, sys_clk_in} = {3{b}};
            {dma_request_two_n, dma_grant_ch8} = {2{~b}};
            step(1);
            chk("cs_n", expansion_chip_select_n, i == 0 ? 2'h2 : i == 1 ? 2'h1 : 2'h3);
            chk("addr", exp_addr, local_addr[7:2]);
            chk("data", {exp_data_out, exp_data_rd}, {local_data_out[47:16], exp_data_in});
            chk("dma", {dma_req_ch7, dma_req_ch8, dma_grant_one_n, dma_grant_two_n}, {~b, b, ~b, b});
            chk("clk", sync_address_clock, sys_clk_in);
        end
    endtask
    task automatic t_free();
        host_req = 1'b1;
        own = 1'b1;
        step(2);
        chk("grants", {host_grant, proc_grant}, 2'h2);
        {host_req, host_done} = 2'h1;
        step(1);
        host_done = 1'b0;
        for (int i = 0; i < 20 && proc_bus_busy !== 1'b1; i++) step(1);
        chk("proc_busy", {host_grant, proc_bus_busy}, 2'h1);
    endtask
    task automatic t_backoff(input logic [1:0] r, input logic [3:0] d);
        {risk, rel_dly, host_req} = {r, d, 1'b1};
        for (int i = 0; i < 20 && suspend_bus_tristate !== 1'b1; i++) step(1);
        chk("suspend", {suspend_bus_tristate, host_grant & proc_bus_busy}, 2'h2);
        for (int i = 0; i < 30 && host_grant !== 1'b1; i++) step(1);
        chk("grant", {host_grant, suspend_bus_tristate, proc_bus_busy}, 3'h6);
        {risk, host_req} = 3'h0;
        step(2);
        chk("released", {host_grant, suspend_bus_tristate}, 2'h0);
        for (int i = 0; i < 20 && proc_bus_busy !== 1'b1; i++) step(1);
        chk("resumed", proc_bus_busy, 1'b1);
    endtask
    task automatic t_dma();
        {dma, host_req, host_write} = 3'h6;
        step(8);
        chk("dma_hold", {host_grant, dma_write_hazard, proc_bus_busy}, 3'h1);
        host_write = 1'b1;
        step(2);
        chk("hazard", dma_write_hazard, 1'b1);
        {dma, host_write} = 2'h0;
        for (int i = 0; i < 20 && host_grant !== 1'b1; i++) step(1);
        chk("dma_done", host_grant, 1'b1);
        host_req = 1'b0;
        step(2);
    endtask
    initial begin
        step(20);
        chk("reset", {host_grant, suspend_bus_tristate, expansion_chip_select_n}, 4'h3);
        rst = 1'b0;
        step(1);
        t_map();
        t_free();
        t_backoff(2'h1, 4'h0);
        t_backoff(2'h2, 4'h3);
        t_backoff(2'h0, 4'h1);
        t_dma();
        results();
    end
endmodule // tb
bind lbba_arbiter lbba_arbiter_monitor #(.STALL_CYC(STALL_CYC)) mon (.*);
